// ### shared/sfr_pkg.sv
// Constants shared by the serial flash reset/unlock command logic.
// Assumes a single 100 MHz core clock and an SPI link sampled as plain inputs.
package sfr_pkg;
  localparam int          CORE_CLK_MHZ     = 100;
  localparam logic [7:0]  CMD_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0]  CMD_RESET_ARM     = 8'h66;
  localparam logic [7:0]  CMD_RESET_EXEC    = 8'h99;
  localparam int          RESET_TIME_US    = 30;
  localparam int          RESET_CYCLES     = RESET_TIME_US * CORE_CLK_MHZ;
  localparam int          PUW_TIME_MS      = 5;
  localparam int          PUW_CYCLES       = PUW_TIME_MS * 1000 * CORE_CLK_MHZ;
  localparam int          LOCK_BITS        = 16;
  localparam int          DIE_COUNT        = 2;
  localparam int          CNT_W            = 16;
  localparam logic [LOCK_BITS-1:0] LOCK_RESET = {LOCK_BITS{1'b1}};
  localparam logic [7:0]  READ_PARAM_RESET = 8'h00;
  localparam logic [2:0]  WRAP_RESET       = 3'h7;
  localparam logic [7:0]  VOL_STATUS_RESET = 8'h00;
endpackage : sfr_pkg

// ### hw/sfr_frame_rx.sv
// Serial frame receiver: synchronises link pins, shifts the first byte on clock rises.
// Assumes link inputs are asynchronous to core_clk and far slower than it.
module sfr_frame_rx
  import sfr_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Link pins
  input  wire logic       select_n,
  input  wire logic       serial_clk,
  input  wire logic       serial_in,
  // Decoded frame
  output logic            frame_done,
  output logic            frame_whole,
  output logic [7:0]      frame_code,
  output logic            frame_active
);
  logic [1:0] sel_sync;
  logic [1:0] clk_sync;
  logic [1:0] din_sync;
  logic       clk_prev;
  logic       sel_prev;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic       got_byte;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_sync <= 2'h3;
      clk_sync <= 2'h0;
      din_sync <= 2'h0;
      clk_prev <= 1'b0;
      sel_prev <= 1'b1;
    end else begin
      sel_sync <= {sel_sync[0], select_n};
      clk_sync <= {clk_sync[0], serial_clk};
      din_sync <= {din_sync[0], serial_in};
      clk_prev <= clk_sync[1];
      sel_prev <= sel_sync[1];
    end
  end

  // Bits of the first byte shift MSB first on each link clock rise within the frame
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift    <= 8'h00;
      bit_cnt  <= 3'h0;
      got_byte <= 1'b0;
    end else if (sel_sync[1]) begin
      bit_cnt  <= 3'h0;
      if (!sel_prev) got_byte <= 1'b0;
    end else if (clk_sync[1] && !clk_prev) begin
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        got_byte <= 1'b1;
        if (!got_byte) shift <= {shift[6:0], din_sync[1]};
      end else if (!got_byte) begin
        shift <= {shift[6:0], din_sync[1]};
      end
    end
  end

  // Frame ends on the select rise; whole only with no partial byte
  always_comb begin
    frame_done   = sel_sync[1] && !sel_prev;
    frame_whole  = got_byte && (bit_cnt == 3'h0);
    frame_code   = shift;
    frame_active = !sel_sync[1];
  end
endmodule // sfr_frame_rx

// ### hw/sfr_core.sv
// Command interpreter for global unlock and two-step software reset.
// Assumes the host respects select framing and the recovery hold-off.
module sfr_core
  import sfr_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Link pins
  input  wire logic                  select_n,
  input  wire logic                  serial_clk,
  input  wire logic                  serial_in,
  // Internal operation status from the array engine
  input  wire logic                  op_running,
  input  wire logic                  op_suspended,
  // Status outputs
  output logic                       busy_flag,
  output logic                       reset_armed,
  output logic                       op_abort,
  output logic [LOCK_BITS-1:0]       lock_bits,
  output logic [DIE_COUNT-1:0]       die_reset,
  output logic                       active_die,
  output logic                       write_latch_flag,
  output logic                       suspend_flag,
  output logic [7:0]                 read_param_bits,
  output logic [2:0]                 wrap_bits,
  output logic [7:0]                 vol_status,
  output logic                       data_at_risk,
  output logic                       cmd_done
);
  typedef enum logic [1:0] {
    SFR_IDLE    = 2'b01,
    SFR_RECOVER = 2'b10
  } sfr_state_type;

  localparam logic [CNT_W-1:0] RESET_CNT = CNT_W'(RESET_CYCLES - 1);

  sfr_state_type   state;
  logic            frame_done;
  logic            frame_whole;
  logic [7:0]      frame_code;
  logic            frame_active;
  logic [CNT_W-1:0] rec_cnt;
  logic            take_cmd;
  logic            do_reset;

  sfr_frame_rx u_rx (
    .core_clk     (core_clk),
    .rst          (rst),
    .select_n     (select_n),
    .serial_clk   (serial_clk),
    .serial_in    (serial_in),
    .frame_done   (frame_done),
    .frame_whole  (frame_whole),
    .frame_code   (frame_code),
    .frame_active (frame_active)
  );

  always_comb begin
    take_cmd = frame_done && frame_whole && (state == SFR_IDLE);
    do_reset = take_cmd && reset_armed && (frame_code == CMD_RESET_EXEC);
  end

  // Recovery timer after an accepted reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state   <= SFR_IDLE;
      rec_cnt <= '0;
    end else begin
      unique case (state)
        SFR_IDLE: begin
          if (do_reset) begin
            state   <= SFR_RECOVER;
            rec_cnt <= RESET_CNT;
          end
        end
        SFR_RECOVER: begin
          if (rec_cnt == '0) state <= SFR_IDLE;
          else rec_cnt <= rec_cnt - CNT_W'(1);
        end
      endcase
    end
  end

  // Arm state: set only by the arm code, cleared by any other whole frame taken in idle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) reset_armed <= 1'b0;
    else if (take_cmd) reset_armed <= (frame_code == CMD_RESET_ARM);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_flag    <= 1'b0;
      op_abort     <= 1'b0;
      die_reset    <= '0;
      data_at_risk <= 1'b0;
      cmd_done     <= 1'b0;
    end else begin
      busy_flag    <= (state == SFR_RECOVER) || do_reset || op_running;
      op_abort     <= do_reset;
      die_reset    <= {DIE_COUNT{do_reset}};
      cmd_done     <= take_cmd;
      if (do_reset && (op_running || op_suspended)) data_at_risk <= 1'b1;
      else if (take_cmd) data_at_risk <= 1'b0;
    end
  end

  // Lock bits and volatile settings
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_bits        <= LOCK_RESET;
      active_die       <= 1'b0;
      write_latch_flag <= 1'b0;
      suspend_flag     <= 1'b0;
      read_param_bits  <= READ_PARAM_RESET;
      wrap_bits        <= WRAP_RESET;
      vol_status       <= VOL_STATUS_RESET;
    end else if (do_reset) begin
      lock_bits        <= LOCK_RESET;
      active_die       <= 1'b0;
      write_latch_flag <= 1'b0;
      suspend_flag     <= 1'b0;
      read_param_bits  <= READ_PARAM_RESET;
      wrap_bits        <= WRAP_RESET;
      vol_status       <= VOL_STATUS_RESET;
    end else begin
      if (take_cmd && frame_code == CMD_GLOBAL_UNLOCK) lock_bits <= '0;
      suspend_flag <= op_suspended;
    end
  end

  // Checks
  sequence s_arm;
    take_cmd && frame_code == CMD_RESET_ARM;
  endsequence
  sequence s_exec;
    take_cmd && frame_code == CMD_RESET_EXEC;
  endsequence

  property p_unlock;
    @(posedge core_clk) disable iff (rst)
      (take_cmd && frame_code == CMD_GLOBAL_UNLOCK && !do_reset) |=> lock_bits == '0;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock did not clear locks");

  // An execute code with no arm in front of it must leave the device running
  property p_arm_exec;
    @(posedge core_clk) disable iff (rst)
      s_exec ##0 !reset_armed |=> !op_abort && state == SFR_IDLE;
  endproperty
  a_arm_exec: assert property (p_arm_exec) else $error("reset without arm");

  property p_disarm;
    @(posedge core_clk) disable iff (rst)
      (take_cmd && frame_code != CMD_RESET_ARM) |=> !reset_armed;
  endproperty
  a_disarm: assert property (p_disarm) else $error("arm not cleared");

  property p_abort;
    @(posedge core_clk) disable iff (rst) do_reset |=> op_abort && die_reset == '1;
  endproperty
  a_abort: assert property (p_abort) else $error("reset not propagated");

  property p_volatile;
    @(posedge core_clk) disable iff (rst)
      do_reset |=> !write_latch_flag && !suspend_flag && wrap_bits == WRAP_RESET
        && read_param_bits == READ_PARAM_RESET && !active_die;
  endproperty
  a_volatile: assert property (p_volatile) else $error("volatile state kept");

  property p_recover;
    @(posedge core_clk) disable iff (rst)
      s_exec ##0 do_reset |=> (state == SFR_RECOVER)[*8];
  endproperty
  a_recover: assert property (p_recover) else $error("recovery too short");

  // A frame that ends during recovery changes neither locks nor the arm state
  property p_no_cmd;
    @(posedge core_clk) disable iff (rst)
      (state == SFR_RECOVER && frame_done) |=> !cmd_done && $stable(lock_bits)
        && $stable(reset_armed);
  endproperty
  a_no_cmd: assert property (p_no_cmd) else $error("command during recovery");

  // A frame with a partial final byte has no effect
  property p_partial;
    @(posedge core_clk) disable iff (rst)
      (frame_done && !frame_whole) |=> !cmd_done && $stable(lock_bits)
        && $stable(reset_armed);
  endproperty
  a_partial: assert property (p_partial) else $error("partial frame acted on");

  property p_busy;
    @(posedge core_clk) disable iff (rst) state == SFR_RECOVER |=> busy_flag;
  endproperty
  a_busy: assert property (p_busy) else $error("busy low during recovery");

  property p_armed_next;
    @(posedge core_clk) disable iff (rst) s_arm |=> reset_armed;
  endproperty
  a_armed_next: assert property (p_armed_next) else $error("arm not taken");
endmodule // sfr_core

// ### testbench/sfr_host_model.sv
// Host side of the link: frames one instruction code per select window.
// Assumes the bench calls send only while no other frame is running.
module sfr_host_model (
  // Link pins
  output logic select_n,
  output logic serial_clk,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end
  // Clock idles low between frames; data is inverted after the last clock fall, before select rises
  task automatic send(input logic [7:0] code, input int nbits);
    select_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serial_in = code[7-i];
      #62.5 serial_clk = 1'b1;
      #62.5 serial_clk = 1'b0;
    end
    serial_in = ~serial_in;
    #62.5 select_n = 1'b1;
  endtask
endmodule // sfr_host_model

// ### testbench/spi_flash_soft_reset_unlock_tb_top.sv
// Bench top for the unlock and software reset command logic.
// Assumes the host model owns the link pins; the bench drives the rest.
module spi_flash_soft_reset_unlock_tb_top
  import sfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic op_running = 1'b0;
  logic op_suspended = 1'b0;
  logic select_n, serial_clk, serial_in, busy_flag, reset_armed, op_abort;
  logic active_die, write_latch_flag, suspend_flag, data_at_risk, cmd_done;
  logic [LOCK_BITS-1:0] lock_bits;
  logic [DIE_COUNT-1:0] die_reset;
  logic [7:0] read_param_bits, vol_status;
  logic [2:0] wrap_bits;
  logic seen_clr = 1'b0;
  logic busy_clr = 1'b0;
  logic abort_seen = 1'b0;
  logic die_seen = 1'b0;
  logic done_seen = 1'b0;
  int busy_cnt = 0;
  int err_total = 0;
  int tests_run = 0;
  always #5 core_clk = ~core_clk;
  // Pulse catchers and recovery length counter
  always @(posedge core_clk) begin
    abort_seen <= !seen_clr && (abort_seen || op_abort === 1'b1);
    die_seen <= !seen_clr && (die_seen || die_reset === {DIE_COUNT{1'b1}});
    done_seen <= !seen_clr && (done_seen || cmd_done === 1'b1);
    busy_cnt <= busy_clr ? 0 : busy_cnt + int'(busy_flag === 1'b1);
  end
  sfr_host_model host_u (.select_n(select_n), .serial_clk(serial_clk),
    .serial_in(serial_in));
  sfr_core dut_u (.core_clk(core_clk), .rst(rst), .select_n(select_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .op_running(op_running),
    .op_suspended(op_suspended), .busy_flag(busy_flag), .reset_armed(reset_armed),
    .op_abort(op_abort), .lock_bits(lock_bits), .die_reset(die_reset),
    .active_die(active_die), .write_latch_flag(write_latch_flag),
    .suspend_flag(suspend_flag), .read_param_bits(read_param_bits),
    .wrap_bits(wrap_bits), .vol_status(vol_status), .data_at_risk(data_at_risk),
    .cmd_done(cmd_done));
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic frame(input logic [7:0] code, input int nbits);
    seen_clr = 1'b1;
    cycles(1);
    seen_clr = 1'b0;
    host_u.send(code, nbits);
    cycles(12);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_flag !== 1'b0 && n < 5000) begin
      cycles(1);
      n++;
    end
    if (n == 5000) begin
      err_total++;
      $display("[FAIL] %0t busy never cleared", $time);
      summarize();
    end
  endtask
  task automatic check_defaults;
    check(lock_bits, LOCK_RESET);
    check(active_die, 1'b0);
    check(read_param_bits, READ_PARAM_RESET);
    check(wrap_bits, WRAP_RESET);
    check(vol_status, VOL_STATUS_RESET);
    check({write_latch_flag, suspend_flag, reset_armed}, 3'h0);
  endtask
  initial begin
    cycles(6);
    rst = 1'b0;
    cycles(3);
    check_defaults();
    check(busy_flag, 1'b0);
    op_running = 1'b1;
    cycles(3);
    check(busy_flag, 1'b1);
    op_running = 1'b0;
    cycles(3);
    check(busy_flag, 1'b0);
    // Only unlock and reset codes are sent, none of them write-type
    frame(CMD_GLOBAL_UNLOCK, 7);
    check({done_seen, lock_bits}, {1'b0, LOCK_RESET});
    frame(CMD_GLOBAL_UNLOCK, 16);
    check({done_seen, lock_bits}, 17'h10000);
    frame(CMD_RESET_ARM, 8);
    check(reset_armed, 1'b1);
    frame(CMD_GLOBAL_UNLOCK, 8);
    check(reset_armed, 1'b0);
    frame(CMD_RESET_EXEC, 8);
    check({abort_seen, busy_flag}, 2'h0);
    check(busy_flag, 1'b0);
    op_suspended = 1'b1;
    frame(CMD_RESET_ARM, 8);
    busy_clr = 1'b1;
    cycles(1);
    busy_clr = 1'b0;
    frame(CMD_RESET_EXEC, 8);
    // The aborted engine drops its suspend state
    op_suspended = 1'b0;
    cycles(2);
    check({abort_seen, busy_flag}, 2'h3);
    check(die_seen, 1'b1);
    check(data_at_risk, 1'b1);
    check_defaults();
    frame(CMD_GLOBAL_UNLOCK, 8);
    check({done_seen, lock_bits}, {1'b0, LOCK_RESET});
    wait_idle();
    check(busy_cnt >= RESET_CYCLES - 10 && busy_cnt <= RESET_CYCLES + 10, 1'b1);
    frame(CMD_GLOBAL_UNLOCK, 12);
    check({done_seen, lock_bits}, {1'b0, LOCK_RESET});
    frame(CMD_GLOBAL_UNLOCK, 8);
    check({data_at_risk, lock_bits}, 17'h00000);
    summarize();
  end
endmodule // spi_flash_soft_reset_unlock_tb_top
